//--- bench/flash_decoder_asserts.sv
// Checker for the flash command decoder, fed by its top ports only.
// Assumes one i_clk domain with asynchronous active-low i_rstn.
`timescale 1ns/1ns
`include "flash_cmd_regs.vh"
module flash_decoder_asserts (
   // Clock and reset
   input wire i_clk,
   input wire i_rstn,
   // Pins and configuration
   input wire i_cs_n,
   input wire i_sclk,
   input wire i_wide_address_flag,
   input wire [3:0] o_io,
   input wire [3:0] o_io_oe,
   // Command events
   input wire o_quad_command_mode,
   input wire o_cmd_start,
   input wire o_cmd_reject,
   input wire [7:0] o_cmd_opcode,
   input wire [31:0] o_cmd_addr,
   input wire [8:0] o_prog_count,
   input wire o_prog_overrun
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // Cycles since the raw serial clock was last seen falling
   reg [3:0] age;
   reg sclk_q;
   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         age <= 4'h0;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= i_sclk;
         if (sclk_q && !i_sclk) age <= 4'h0;
         else if (age != 4'hF) age <= age + 4'h1;
      end
   end
   property p_reset_single;
      $rose(i_rstn) |-> !o_quad_command_mode;
   endproperty
   a_reset_single: assert property (p_reset_single) else $error("mode set after reset");
   property p_enter;
      $rose(o_quad_command_mode) |-> o_cmd_opcode == `OP_ENTER_QUAD && i_cs_n;
   endproperty
   a_enter: assert property (p_enter) else $error("quad mode without enter");
   property p_exit;
      $fell(o_quad_command_mode) |-> o_cmd_opcode == `OP_EXIT_QUAD && i_cs_n;
   endproperty
   a_exit: assert property (p_exit) else $error("quad mode left without exit");
   property p_quad_lanes;
      o_quad_command_mode && o_io_oe != 4'h0 |-> o_io_oe == 4'hF;
   endproperty
   a_quad_lanes: assert property (p_quad_lanes) else $error("quad output narrow");
   property p_oe_legal;
      o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF};
   endproperty
   a_oe_legal: assert property (p_oe_legal) else $error("bad enable set");
   property p_release;
      $rose(i_cs_n) |-> ##[1:6] o_io_oe == 4'h0;
   endproperty
   a_release: assert property (p_release) else $error("drive after deselect");
   property p_reject_quiet;
      o_cmd_reject |-> o_io_oe == 4'h0 [*4];
   endproperty
   a_reject_quiet: assert property (p_reject_quiet) else $error("drive after reject");
   property p_commit_cs;
      o_cmd_start && (o_cmd_opcode inside {`OP_SECTOR_CLEAR, `OP_HALF_BLOCK_CLEAR,
         `OP_BLOCK_CLEAR, `OP_CHIP_CLEAR_A, `OP_CHIP_CLEAR_B, `OP_PAGE_WRITE,
         `OP_QUAD_PAGE_WRITE}) |-> i_cs_n && !o_cmd_reject;
   endproperty
   a_commit_cs: assert property (p_commit_cs) else $error("commit while selected");
   property p_page_limit;
      o_prog_count <= `PAGE_BYTES;
   endproperty
   a_page_limit: assert property (p_page_limit) else $error("count over page");
   property p_short_addr;
      o_cmd_start && !i_wide_address_flag |-> o_cmd_addr[31:24] == 8'h00;
   endproperty
   a_short_addr: assert property (p_short_addr) else $error("wide address bits");
   property p_out_edge;
      $changed(o_io) && o_io_oe != 4'h0 && o_cmd_opcode != `OP_FOUR_LINE_DOUBLE_RATE_READ
         |-> age >= 4'h1 && age <= 4'h6;
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("output off falling edge");
   c_start: cover property (o_cmd_start);
   c_reject: cover property (o_cmd_reject);
   c_quad: cover property ($rose(o_quad_command_mode));
   c_overrun: cover property ($rose(o_prog_overrun));
endmodule // flash_decoder_asserts
bind quad_serial_flash_command_decoder flash_decoder_asserts i_chk (.i_clk(i_clk),
   .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .o_io(o_io), .o_io_oe(o_io_oe),
   .i_wide_address_flag(i_wide_address_flag), .o_quad_command_mode(o_quad_command_mode),
   .o_cmd_start(o_cmd_start), .o_cmd_reject(o_cmd_reject), .o_cmd_opcode(o_cmd_opcode),
   .o_cmd_addr(o_cmd_addr), .o_prog_count(o_prog_count), .o_prog_overrun(o_prog_overrun));

//--- bench/flash_host_model.sv
// Host controller model: chip select, mode 0 serial clock and data lanes.
// Assumes the bench resolves the shared lanes from the device output enables alone.
`timescale 1ns/1ns
module flash_host_model (
   // Clock
   input wire i_clk,
   // Lanes as seen on the wire
   input wire [3:0] i_io,
   // Host pins
   output logic o_cs_n = 1'b1,
   output logic o_sclk = 1'b0,
   output logic [3:0] o_io = 4'h0
);
   // Half period of 5 cycles gives the 80 ns serial clock
   task automatic half();
      repeat (5) @(negedge i_clk);
   endtask
   task automatic sel();
      @(negedge i_clk);
      o_cs_n = 1'b0;
      half();
   endtask
   // Callers end frames on whole bytes unless wr sends ex extra bits; long high time suits mode changes
   task automatic desel();
      half();
      o_cs_n = 1'b1;
      o_io = ~o_io;
      repeat (40) @(negedge i_clk);
   endtask
   // Left-aligned d, n bits on ln lanes, MSB first; data set while clock is low
   task automatic xfer(input logic [31:0] d, input int n, input int ln,
                       output logic [31:0] r);
      int i;
      r = 32'h0;
      for (i = 0; i < n; i = i + ln) begin
         o_io = d[31:28] >> (4 - ln);
         d = d << ln;
         half();
         o_sclk = 1'b1;
         r = (r << ln) | ((ln == 1) ? {31'h0, i_io[1]} : {28'h0, i_io & (4'hF >> (4 - ln))});
         half();
         o_sclk = 1'b0;
      end
   endtask
endmodule // flash_host_model

//--- bench/quad_serial_flash_command_decoder_tb_top.sv
// Self-checking bench for the flash command decoder with a host model.
// Assumes 125 MHz i_clk; stimulus changes at falling edges.
`timescale 1ns/1ns
`include "flash_cmd_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR %0t got %0h want %0h", $time, (a), (b)); end end
module quad_serial_flash_command_decoder_tb_top;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic wide = 1'b0;
   logic [7:0] rd = 8'hA5;
   logic pr = 1'b0;
   logic [31:0] r;
   wire cs_n, sclk, qm, st, rj, rn, pv, ov;
   wire [3:0] h_io, d_io, d_oe, io_w;
   wire [7:0] op, pd;
   wire [31:0] ad;
   wire [8:0] pc;
   int num_errors = 0;
   int check_count = 0;
   int n_st = 0;
   int n_rj = 0;
   always #4 i_clk = ~i_clk;
   assign io_w = (d_oe & d_io) | (~d_oe & h_io);
   // Pulses are counted mid-cycle, away from the edge that launches them
   always @(negedge i_clk) begin
      n_st <= n_st + (st === 1'b1);
      n_rj <= n_rj + (rj === 1'b1);
   end
   // Array side: next byte once the current one is taken
   always @(negedge i_clk) if (rn === 1'b1) rd <= rd + 8'h01;
   flash_host_model i_host (.i_clk(i_clk), .i_io(io_w), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_io(h_io));
   quad_serial_flash_command_decoder i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(cs_n),
      .i_sclk(sclk), .i_io(io_w), .o_io(d_io), .o_io_oe(d_oe), .i_config_reg(cfg),
      .i_wide_address_flag(wide), .o_quad_command_mode(qm), .o_cmd_start(st),
      .o_cmd_reject(rj), .o_cmd_opcode(op), .o_cmd_addr(ad), .o_prog_count(pc),
      .o_prog_overrun(ov), .i_rd_data(rd), .o_rd_next(rn), .o_prog_valid(pv),
      .o_prog_data(pd), .i_prog_ready(pr));
   task automatic complete_run();
      $display("Errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rd_one(input logic [7:0] c, input int cl, al, dl, dum);
      int s;
      logic [7:0] e;
      logic [7:0] e1;
      logic [31:0] a;
      s = n_st;
      e = rd;
      e1 = e + 8'h01;
      // Rising-edge samples of a double-rate stream see the high nibble of each byte
      if (c == `OP_FOUR_LINE_DOUBLE_RATE_READ) e = {e[7:4], e1[7:4]};
      a = wide ? 32'h5A3C961E : 32'h003C961E;
      i_host.sel();
      i_host.xfer({c, 24'h0}, 8, cl, r);
      i_host.xfer(wide ? a : a << 8, wide ? 32 : 24, al, r);
      i_host.xfer(32'h0, dum * 4, 4, r);
      if (dl > 0) begin
         i_host.xfer(32'h0, 8, dl, r);
         `CHK(r[7:0], e)
         `CHK(d_oe, (dl == 1) ? 4'h2 : (dl == 2) ? 4'h3 : 4'hF)
      end
      `CHK(n_st - s, 1)
      `CHK(op, c)
      `CHK(ad, a)
      i_host.desel();
      `CHK(d_oe, 4'h0)
   endtask
   task automatic wr(input logic [7:0] c, input int cl, al, nb, ex);
      int s;
      int t;
      int k;
      s = n_st;
      t = n_rj;
      i_host.sel();
      i_host.xfer({c, 24'h0}, 8, cl, r);
      if (al > 0) i_host.xfer(32'h00012300, 24, al, r);
      for (k = 0; k < nb; k++) i_host.xfer({8'h10 + k[7:0], 24'h0}, 8, al, r);
      i_host.xfer(32'h0, ex, 1, r);
      i_host.desel();
      `CHK(n_st - s, (ex == 0) ? 1 : 0)
      `CHK(n_rj - t, (ex == 0) ? 0 : 1)
   endtask
   task automatic rej(input logic [7:0] c, input int cl);
      int t;
      t = n_rj;
      i_host.sel();
      i_host.xfer({c, 24'h0}, 16, cl, r);
      `CHK(n_rj - t, 1)
      `CHK(d_oe, 4'h0)
      i_host.desel();
   endtask
   task automatic mode(input logic [7:0] c, input int cl, input logic e);
      i_host.sel();
      i_host.xfer({c, 24'h0}, 8, cl, r);
      i_host.desel();
      `CHK(qm, e)
   endtask
   // Fill past capacity with the drain stalled, then empty it
   task automatic t_fifo();
      int k;
      logic [7:0] f;
      k = 0;
      f = 8'h00;
      wr(`OP_PAGE_WRITE, 1, 1, 34, 0);
      `CHK(pc, 9'h022)
      `CHK(ov, 1'b1)
      pr = 1'b1;
      // Drain side is read mid-cycle, where it is settled before the edge takes it
      repeat (40) begin
         if (pv === 1'b1) begin
            if (k == 0) f = pd;
            k++;
         end
         @(negedge i_clk);
      end
      `CHK(k, 33)
      `CHK(f, 8'h10)
      `CHK(pv, 1'b0)
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      @(negedge i_clk);
      i_rstn = 1'b1;
      repeat (4) @(negedge i_clk);
      `CHK(qm, 1'b0)
      `CHK(d_oe, 4'h0)
      rd_one(`OP_READ, 1, 1, 1, 0);
      rd_one(`OP_FAST_READ, 1, 1, 1, 8);
      rd_one(`OP_TWO_LINE_IO_READ, 1, 2, 2, 8);
      rd_one(`OP_DUAL_OUTPUT_READ, 1, 1, 2, 8);
      rd_one(`OP_FOUR_LINE_IO_READ, 1, 4, 4, 6);
      rd_one(`OP_FOUR_LINE_READ_SHORT_DUMMY, 1, 4, 4, 4);
      rd_one(`OP_QUAD_OUTPUT_READ, 1, 1, 4, 8);
      rd_one(`OP_FOUR_LINE_DOUBLE_RATE_READ, 1, 4, 4, 6);
      rej(8'hA7, 1);
      wr(`OP_SECTOR_CLEAR, 1, 1, 0, 0);
      wr(`OP_HALF_BLOCK_CLEAR, 1, 1, 0, 0);
      wr(`OP_BLOCK_CLEAR, 1, 1, 0, 0);
      wr(`OP_CHIP_CLEAR_A, 1, 0, 0, 0);
      wr(`OP_CHIP_CLEAR_B, 1, 0, 0, 0);
      wr(`OP_SECTOR_CLEAR, 1, 1, 0, 3);
      t_fifo();
      wr(`OP_QUAD_PAGE_WRITE, 1, 4, 2, 0);
      mode(`OP_ENTER_QUAD, 1, 1'b1);
      rej(`OP_READ, 4);
      rej(`OP_TWO_LINE_IO_READ, 4);
      rej(`OP_DUAL_OUTPUT_READ, 4);
      rej(`OP_QUAD_OUTPUT_READ, 4);
      rej(`OP_QUAD_PAGE_WRITE, 4);
      wide = 1'b1;
      cfg = 8'h40;
      rd_one(`OP_FAST_READ, 4, 4, 4, 4);
      cfg = 8'hC0;
      rd_one(`OP_FOUR_LINE_IO_READ, 4, 4, 4, 10);
      wide = 1'b0;
      rd_one(`OP_FOUR_LINE_READ_SHORT_DUMMY, 4, 4, 4, 4);
      wr(`OP_PAGE_WRITE, 4, 4, 1, 0);
      wr(`OP_CHIP_CLEAR_A, 4, 0, 0, 0);
      mode(`OP_EXIT_QUAD, 4, 1'b0);
      rd_one(`OP_READ, 1, 1, 1, 0);
      complete_run();
   end
endmodule // quad_serial_flash_command_decoder_tb_top

//--- logic/flash_cmd_regs.vh
// Opcodes, field positions, reset values and counts of the flash command decoder.
// Included by the decoder; holds definitions only.
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

// Mode change
`define OP_ENTER_QUAD 8'h35
`define OP_EXIT_QUAD 8'hF5
// Array reads
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_TWO_LINE_IO_READ 8'hBB
`define OP_DUAL_OUTPUT_READ 8'h3B
`define OP_FOUR_LINE_IO_READ 8'hEB
`define OP_FOUR_LINE_READ_SHORT_DUMMY 8'hE7
`define OP_QUAD_OUTPUT_READ 8'h6B
`define OP_FOUR_LINE_DOUBLE_RATE_READ 8'hED
// Program and erase
`define OP_PAGE_WRITE 8'h02
`define OP_QUAD_PAGE_WRITE 8'h38
`define OP_SECTOR_CLEAR 8'h20
`define OP_HALF_BLOCK_CLEAR 8'h52
`define OP_BLOCK_CLEAR 8'hD8
`define OP_CHIP_CLEAR_A 8'h60
`define OP_CHIP_CLEAR_B 8'hC7

// Configuration register field positions
`define CFG_DUMMY_SELECT_LOW_BIT 6
`define CFG_DUMMY_SELECT_HIGH_BIT 7

// Reset values
`define QUAD_COMMAND_MODE_RESET 1'b0

// Address phase length in bits
`define ADDR_BITS_SHORT 6'h18
`define ADDR_BITS_WIDE 6'h20

// Dummy cycle counts
`define DUMMY_10 5'h0A
`define DUMMY_8 5'h08
`define DUMMY_6 5'h06
`define DUMMY_4 5'h04
`define DUMMY_NONE 5'h00

// Page size in bytes
`define PAGE_BYTES 9'h100

// Program data buffer
`define PROG_FIFO_WIDTH 8
`define PROG_FIFO_DEPTH 32
`define PROG_FIFO_AW 5

`endif

//--- logic/prog_fifo.v
// Program data buffer: a small memory with registered output word.
// Assumes one clock domain; writer and reader both use valid/ready.
`timescale 1ns/1ns
module prog_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rstn,
   // Fill side
   input wire i_valid,
   input wire [WIDTH-1:0] i_data,
   output wire o_ready,
   // Drain side
   output reg o_valid,
   output reg [WIDTH-1:0] o_data,
   input wire i_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wp;
   reg [AW:0] rp;
   wire empty;
   wire full;
   wire load;
   wire push;

   assign empty = (wp == rp);
   assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign o_ready = ~full;
   assign push = i_valid & ~full;
   // Output word refills whenever it is free or being taken
   assign load = ~empty & (~o_valid | i_ready);

   always @(posedge i_clk) begin
      if (push) begin
         mem[wp[AW-1:0]] <= i_data;
      end
   end

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wp <= {(AW+1){1'b0}};
         rp <= {(AW+1){1'b0}};
         o_valid <= 1'b0;
         o_data <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (load) begin
            o_data <= mem[rp[AW-1:0]];
            o_valid <= 1'b1;
            rp <= rp + 1'b1;
         end else if (i_ready) begin
            o_valid <= 1'b0;
         end
      end
   end
endmodule // prog_fifo

//--- logic/quad_serial_flash_command_decoder.v
// Command front end of a serial NOR flash: opcode, address, dummy and data phases,
// single-line and quad command modes.
// Assumes all flash pins are asynchronous to i_clk and the serial clock runs at
// well under a quarter of the i_clk rate; array timing lives elsewhere.
`timescale 1ns/1ns
`include "flash_cmd_regs.vh"

module quad_serial_flash_command_decoder (
   // Clock and reset
   input wire i_clk,
   input wire i_rstn,
   // Flash pins
   input wire i_cs_n,
   input wire i_sclk,
   input wire [3:0] i_io,
   output reg [3:0] o_io,
   output reg [3:0] o_io_oe,
   // Configuration from the register block
   input wire [7:0] i_config_reg,
   input wire i_wide_address_flag,
   // Command events to the array engine
   output reg o_quad_command_mode,
   output reg o_cmd_start,
   output reg o_cmd_reject,
   output reg [7:0] o_cmd_opcode,
   output reg [31:0] o_cmd_addr,
   output reg [8:0] o_prog_count,
   output reg o_prog_overrun,
   // Read data from the array
   input wire [7:0] i_rd_data,
   output reg o_rd_next,
   // Program data to the array
   output wire o_prog_valid,
   output wire [7:0] o_prog_data,
   input wire i_prog_ready
);
   localparam [2:0] ST_OPC = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_DUMMY = 3'h2;
   localparam [2:0] ST_RDATA = 3'h3;
   localparam [2:0] ST_WDATA = 3'h4;
   localparam [2:0] ST_HOLD = 3'h5;
   localparam [2:0] ST_STBY = 3'h6;

   // Opcode accepted in the current mode
   function cmd_ok;
      input [7:0] op;
      input quad;
      begin
         case (op)
            `OP_FAST_READ, `OP_FOUR_LINE_IO_READ, `OP_FOUR_LINE_READ_SHORT_DUMMY,
            `OP_FOUR_LINE_DOUBLE_RATE_READ, `OP_PAGE_WRITE, `OP_SECTOR_CLEAR,
            `OP_HALF_BLOCK_CLEAR, `OP_BLOCK_CLEAR, `OP_CHIP_CLEAR_A, `OP_CHIP_CLEAR_B,
            `OP_ENTER_QUAD, `OP_EXIT_QUAD:
               cmd_ok = 1'b1;
            `OP_READ, `OP_TWO_LINE_IO_READ, `OP_DUAL_OUTPUT_READ,
            `OP_QUAD_OUTPUT_READ, `OP_QUAD_PAGE_WRITE:
               cmd_ok = ~quad;
            default:
               cmd_ok = 1'b0;
         endcase
      end
   endfunction

   function is_read;
      input [7:0] op;
      begin
         case (op)
            `OP_READ, `OP_FAST_READ, `OP_TWO_LINE_IO_READ, `OP_DUAL_OUTPUT_READ,
            `OP_FOUR_LINE_IO_READ, `OP_FOUR_LINE_READ_SHORT_DUMMY,
            `OP_QUAD_OUTPUT_READ, `OP_FOUR_LINE_DOUBLE_RATE_READ:
               is_read = 1'b1;
            default:
               is_read = 1'b0;
         endcase
      end
   endfunction

   // Lines used by the address phase
   function [2:0] addr_lanes;
      input [7:0] op;
      input quad;
      begin
         if (quad) begin
            addr_lanes = 3'h4;
         end else begin
            case (op)
               `OP_TWO_LINE_IO_READ: addr_lanes = 3'h2;
               `OP_FOUR_LINE_IO_READ, `OP_FOUR_LINE_READ_SHORT_DUMMY,
               `OP_FOUR_LINE_DOUBLE_RATE_READ, `OP_QUAD_PAGE_WRITE: addr_lanes = 3'h4;
               default: addr_lanes = 3'h1;
            endcase
         end
      end
   endfunction

   // Lines used by the data phase, in or out
   function [2:0] data_lanes;
      input [7:0] op;
      input quad;
      begin
         if (quad) begin
            data_lanes = 3'h4;
         end else begin
            case (op)
               `OP_TWO_LINE_IO_READ, `OP_DUAL_OUTPUT_READ: data_lanes = 3'h2;
               `OP_FOUR_LINE_IO_READ, `OP_FOUR_LINE_READ_SHORT_DUMMY,
               `OP_QUAD_OUTPUT_READ, `OP_FOUR_LINE_DOUBLE_RATE_READ,
               `OP_QUAD_PAGE_WRITE: data_lanes = 3'h4;
               default: data_lanes = 3'h1;
            endcase
         end
      end
   endfunction

   function [4:0] dummy_cycles;
      input [7:0] op;
      input [1:0] dc;
      begin
         case (op)
            `OP_FAST_READ, `OP_TWO_LINE_IO_READ:
               dummy_cycles = (dc == 2'h1) ? `DUMMY_4 : `DUMMY_8;
            `OP_DUAL_OUTPUT_READ, `OP_QUAD_OUTPUT_READ:
               dummy_cycles = `DUMMY_8;
            `OP_FOUR_LINE_IO_READ:
               case (dc)
                  2'h0: dummy_cycles = `DUMMY_6;
                  2'h1: dummy_cycles = `DUMMY_4;
                  2'h2: dummy_cycles = `DUMMY_8;
                  default: dummy_cycles = `DUMMY_10;
               endcase
            `OP_FOUR_LINE_READ_SHORT_DUMMY:
               dummy_cycles = `DUMMY_4;
            `OP_FOUR_LINE_DOUBLE_RATE_READ:
               case (dc)
                  2'h2: dummy_cycles = `DUMMY_8;
                  2'h3: dummy_cycles = `DUMMY_10;
                  default: dummy_cycles = `DUMMY_6;
               endcase
            default:
               dummy_cycles = `DUMMY_NONE;
         endcase
      end
   endfunction

   // Top bits of a byte placed on the pins for the given lane count
   function [3:0] lane_bits;
      input [7:0] b;
      input [2:0] w;
      begin
         case (w)
            3'h4: lane_bits = b[7:4];
            3'h2: lane_bits = {2'h0, b[7:6]};
            default: lane_bits = {2'h0, b[7], 1'b0};
         endcase
      end
   endfunction

   function [3:0] lane_enable;
      input [2:0] w;
      begin
         case (w)
            3'h4: lane_enable = 4'hF;
            3'h2: lane_enable = 4'h3;
            default: lane_enable = 4'h2;
         endcase
      end
   endfunction

   // Pin synchronisers
   reg cs_m, cs_s, cs_d;
   reg sclk_m, sclk_s, sclk_d;
   reg [3:0] io_m, io_s;

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cs_m <= 1'b1;
         cs_s <= 1'b1;
         cs_d <= 1'b1;
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         io_m <= 4'h0;
         io_s <= 4'h0;
      end else begin
         cs_m <= i_cs_n;
         cs_s <= cs_m;
         cs_d <= cs_s;
         sclk_m <= i_sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         io_m <= i_io;
         io_s <= io_m;
      end
   end

   wire cs_rise = cs_s & ~cs_d;
   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;

   reg [2:0] state;
   reg [2:0] lanes;
   reg [5:0] cnt;
   reg [4:0] dcnt;
   reg [31:0] sh;
   reg [7:0] obuf;
   reg [3:0] bleft;
   reg dtr;
   reg fifo_push;
   reg [7:0] fifo_data;
   wire fifo_ready;

   wire [5:0] cnt_n = cnt + {3'h0, lanes};
   wire [31:0] nsh = (lanes == 3'h4) ? {sh[27:0], io_s} :
                     (lanes == 3'h2) ? {sh[29:0], io_s[1:0]} : {sh[30:0], io_s[0]};
   // Inputs use SI alone in single-line phases
   wire [7:0] op_n = nsh[7:0];
   wire [5:0] addr_bits = i_wide_address_flag ? `ADDR_BITS_WIDE : `ADDR_BITS_SHORT;
   wire [31:0] addr_n = i_wide_address_flag ? nsh : {8'h00, nsh[23:0]};
   wire [1:0] dc_sel = {i_config_reg[`CFG_DUMMY_SELECT_HIGH_BIT],
                        i_config_reg[`CFG_DUMMY_SELECT_LOW_BIT]};
   wire [4:0] dummy_n = dummy_cycles(o_cmd_opcode, dc_sel);
   // Double-rate data moves on both serial clock edges
   wire out_edge = (state == ST_RDATA) && (sclk_fall || (dtr && sclk_rise));
   wire [2:0] wlen = data_lanes(o_cmd_opcode, o_quad_command_mode);
   wire write_type = (o_cmd_opcode == `OP_PAGE_WRITE) || (o_cmd_opcode == `OP_QUAD_PAGE_WRITE);

   always @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= ST_OPC;
         lanes <= 3'h1;
         cnt <= 6'h00;
         dcnt <= 5'h00;
         sh <= 32'h0000_0000;
         obuf <= 8'h00;
         bleft <= 4'h0;
         dtr <= 1'b0;
         fifo_push <= 1'b0;
         fifo_data <= 8'h00;
         o_io <= 4'h0;
         o_io_oe <= 4'h0;
         o_quad_command_mode <= `QUAD_COMMAND_MODE_RESET;
         o_cmd_start <= 1'b0;
         o_cmd_reject <= 1'b0;
         o_cmd_opcode <= 8'h00;
         o_cmd_addr <= 32'h0000_0000;
         o_prog_count <= 9'h000;
         o_prog_overrun <= 1'b0;
         o_rd_next <= 1'b0;
      end else begin
         o_cmd_start <= 1'b0;
         o_cmd_reject <= 1'b0;
         o_rd_next <= 1'b0;
         fifo_push <= 1'b0;
         if (cs_s) begin
            // Deselected: outputs released, next select starts a fresh opcode
            state <= ST_OPC;
            lanes <= o_quad_command_mode ? 3'h4 : 3'h1;
            cnt <= 6'h00;
            sh <= 32'h0000_0000;
            o_io_oe <= 4'h0;
            dtr <= 1'b0;
            if (cs_rise) begin
               case (state)
                  ST_HOLD: begin
                     if (cnt[2:0] != 3'h0) begin
                        o_cmd_reject <= 1'b1;
                     end else if (o_cmd_opcode == `OP_ENTER_QUAD) begin
                        // Quad enable bit lives elsewhere and is left alone
                        o_quad_command_mode <= 1'b1;
                     end else if (o_cmd_opcode == `OP_EXIT_QUAD) begin
                        o_quad_command_mode <= 1'b0;
                     end else begin
                        o_cmd_start <= 1'b1;
                     end
                  end
                  ST_WDATA: begin
                     if (cnt == 6'h00 && o_prog_count != 9'h000) begin
                        o_cmd_start <= 1'b1;
                     end else begin
                        o_cmd_reject <= 1'b1;
                     end
                  end
                  ST_OPC, ST_ADDR: begin
                     if (state == ST_ADDR || cnt != 6'h00) begin
                        o_cmd_reject <= 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end else begin
            if (sclk_rise) begin
               case (state)
                  ST_OPC: begin
                     sh <= nsh;
                     cnt <= cnt_n;
                     if (cnt_n == 6'h08) begin
                        cnt <= 6'h00;
                        o_cmd_opcode <= op_n;
                        o_prog_count <= 9'h000;
                        o_prog_overrun <= 1'b0;
                        if (!cmd_ok(op_n, o_quad_command_mode)) begin
                           state <= ST_STBY;
                           o_cmd_reject <= 1'b1;
                        end else if (op_n == `OP_ENTER_QUAD || op_n == `OP_EXIT_QUAD ||
                                     op_n == `OP_CHIP_CLEAR_A || op_n == `OP_CHIP_CLEAR_B) begin
                           state <= ST_HOLD;
                        end else begin
                           state <= ST_ADDR;
                           lanes <= addr_lanes(op_n, o_quad_command_mode);
                        end
                     end
                  end
                  ST_ADDR: begin
                     sh <= nsh;
                     cnt <= cnt_n;
                     if (cnt_n == addr_bits) begin
                        cnt <= 6'h00;
                        o_cmd_addr <= addr_n;
                        lanes <= wlen;
                        if (is_read(o_cmd_opcode)) begin
                           o_cmd_start <= 1'b1;
                           bleft <= 4'h0;
                           dtr <= (o_cmd_opcode == `OP_FOUR_LINE_DOUBLE_RATE_READ);
                           dcnt <= dummy_n;
                           state <= (dummy_n == `DUMMY_NONE) ? ST_RDATA : ST_DUMMY;
                        end else if (write_type) begin
                           state <= ST_WDATA;
                        end else begin
                           state <= ST_HOLD;
                        end
                     end
                  end
                  ST_DUMMY: begin
                     dcnt <= dcnt - 5'h01;
                     if (dcnt == 5'h01) begin
                        state <= ST_RDATA;
                     end
                  end
                  ST_WDATA: begin
                     sh <= nsh;
                     cnt <= cnt_n;
                     if (cnt_n == 6'h08) begin
                        cnt <= 6'h00;
                        // Host cannot be paused, so a full buffer drops the byte and flags it
                        if (fifo_ready) begin
                           fifo_push <= 1'b1;
                           fifo_data <= op_n;
                        end else begin
                           o_prog_overrun <= 1'b1;
                        end
                        if (o_prog_count != `PAGE_BYTES) begin
                           o_prog_count <= o_prog_count + 9'h001;
                        end
                     end
                  end
                  ST_HOLD: begin
                     cnt <= cnt_n;
                  end
                  default: begin
                  end
               endcase
            end
            if (out_edge) begin
               // Byte stream runs until chip select rises
               o_io_oe <= lane_enable(wlen);
               if (bleft == 4'h0) begin
                  o_io <= lane_bits(i_rd_data, wlen);
                  obuf <= i_rd_data << wlen;
                  bleft <= 4'h8 - {1'b0, wlen};
                  o_rd_next <= 1'b1;
               end else begin
                  o_io <= lane_bits(obuf, wlen);
                  obuf <= obuf << wlen;
                  bleft <= bleft - {1'b0, wlen};
               end
            end else if (state == ST_STBY) begin
               o_io_oe <= 4'h0;
            end
         end
      end
   end

   prog_fifo #(
      .WIDTH(`PROG_FIFO_WIDTH),
      .DEPTH(`PROG_FIFO_DEPTH),
      .AW(`PROG_FIFO_AW)
   ) u_prog_fifo (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_valid(fifo_push),
      .i_data(fifo_data),
      .o_ready(fifo_ready),
      .o_valid(o_prog_valid),
      .o_data(o_prog_data),
      .i_ready(i_prog_ready)
   );
endmodule // quad_serial_flash_command_decoder
